// [tcic_pkg.sv]
// Constants for the first timer's compare, capture and interrupt control block
`default_nettype none
package tcic_pkg;
    // ----------------------------------------------------------------
    // Register indices and byte addresses (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam logic [7:0]  IDX_PIN_ACTION   = 8'h20;
    localparam logic [7:0]  IDX_IRQ_ENABLE1  = 8'h22;
    localparam logic [7:0]  IDX_FLAGS1       = 8'h23;
    localparam logic [7:0]  IDX_IRQ_ENABLE2  = 8'h24;
    localparam logic [7:0]  IDX_FLAGS2       = 8'h25;
    localparam logic [7:0]  IDX_AUX_CONTROL  = 8'h26;
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] ADDR_PIN_ACTION  = {2'b00, IDX_PIN_ACTION, 2'b00};
    localparam logic [11:0] ADDR_IRQ_ENABLE1 = {2'b00, IDX_IRQ_ENABLE1, 2'b00};
    localparam logic [11:0] ADDR_FLAGS1      = {2'b00, IDX_FLAGS1, 2'b00};
    localparam logic [11:0] ADDR_IRQ_ENABLE2 = {2'b00, IDX_IRQ_ENABLE2, 2'b00};
    localparam logic [11:0] ADDR_FLAGS2      = {2'b00, IDX_FLAGS2, 2'b00};
    localparam logic [11:0] ADDR_AUX_CONTROL = {2'b00, IDX_AUX_CONTROL, 2'b00};

    // ----------------------------------------------------------------
    // Reset values and counter maximum
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [3:0]  RST_NIBBLE       = 4'h0;
    localparam logic [1:0]  RST_PRESCALE     = 2'h0;
    localparam logic [15:0] RST_COUNTER      = 16'h0000;
    localparam logic [15:0] COUNTER_MAX      = 16'hffff;
    localparam logic [31:0] RST_WORD         = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FLG1_CMP1      = 7;   // Compare 1..4 at 7..4
    localparam int FLG1_CH45      = 3;
    localparam int FLG1_CAP1      = 2;   // Capture 1..3 at 2..0
    localparam int FLG2_OVERFLOW  = 3;   // Within the upper nibble
    localparam int FLG2_PERIODIC  = 2;
    localparam int FLG2_ACC_OVF   = 1;
    localparam int FLG2_ACC_EDGE  = 0;
    localparam int AUX_CH45_SEL   = 0;
    localparam int AUX_SPECIAL    = 1;
    localparam int AUX_T3_OVR     = 2;
    localparam int AUX_T3_PR_LO   = 3;   // Two bits at 4..3

    // ----------------------------------------------------------------
    // Pin action codes and capture edge codes
    // ----------------------------------------------------------------
    localparam logic [1:0] ACT_DETACH = 2'b00;
    localparam logic [1:0] ACT_TOGGLE = 2'b01;
    localparam logic [1:0] ACT_LOW    = 2'b10;
    localparam logic [1:0] ACT_HIGH   = 2'b11;
    localparam logic [1:0] EDGE_RISE  = 2'b01;
    localparam logic [1:0] EDGE_FALL  = 2'b10;
    localparam logic [1:0] EDGE_ANY   = 2'b11;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         PRESCALE_WINDOW_CYCLES = 64;
    localparam logic [6:0] PRESCALE_WINDOW = 7'(PRESCALE_WINDOW_CYCLES);
    localparam logic [3:0] DIV_LIMIT_1  = 4'h0;   // Divide by 1
    localparam logic [3:0] DIV_LIMIT_4  = 4'h3;
    localparam logic [3:0] DIV_LIMIT_8  = 4'h7;
    localparam logic [3:0] DIV_LIMIT_16 = 4'hf;
endpackage : tcic_pkg
`default_nettype wire

// [tcic_timer1_ctrl.sv]
// First timer compare pin action, interrupt flag/enable and prescale control
//
// Notes on behaviour
// [RULE1] Compare of channels 2-5 applies pair: 00 detach, 01 toggle, 10 low, 11 high.
// [RULE2] Channel 5 compare and pin action work only while the channel 4/5 select is clear.
// [RULE3] Each enable bit gates the flag at the same bit; compare 1-4 top, capture 3 bit 0.
// [RULE4] An interrupt is requested while a channel flag and its enable are both set.
// [RULE5] Shared 4/5 enable serves capture 4 when select is one, compare 5 when zero.
// [RULE6] Flags clear only where software writes a one to their bit position.
// [RULE7] Compare flags 1-4 set each time the counter equals the compare value.
// [RULE8] Shared 4/5 flag set by capture-4 edge or compare-5 match per select.
// [RULE9] Capture flags 1-3 set on each configured active edge of their input pin.
// [RULE10] Upper nibble of second enable gates second flags; overflow enable requests irq.
// [RULE11] Second enable register also holds periodic and two accumulator enables.
// [RULE12] Prescale select divides the counter clock by 1, 4, 8 or 16.
// [RULE13] In normal mode prescale takes one write, only within 64 cycles after reset.
// [RULE14] Prescale select also drives third timer prescale unless overridden.
// [RULE15] Overflow flag set when the counter rolls from FFFF to 0000.
// [RULE16] Low nibble of the second flag register always reads zero.
// [RULE17] Flags set regardless of their enable bits.
// [RULE18] Each source drives its own separate interrupt request.
// [RULE19] Pin action happens on every compare, whether or not the flag was cleared.
// [RULE20] Compare values are checked against the counter only in the first cycle of each new counter value.
// [RULE21] Writing zero leaves a flag alone; a set in the clearing cycle wins.
`timescale 1ns/1ps
`default_nettype none
module tcic_timer1_ctrl
    import tcic_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    // APB slave
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Compare values, index 0 is channel 1
    input  wire logic [4:0][15:0]   compare_value,
    // Capture pins, index 0..3 is capture 1..4, with two edge bits each
    input  wire logic [3:0]         capture_pin,
    input  wire logic [7:0]         capture_edge_select,
    // Event pulses from the periodic and accumulator logic
    input  wire logic               periodic_event,
    input  wire logic               accumulator_overflow_event,
    input  wire logic               accumulator_edge_event,
    // Compare pins, index 0..3 is channel 2..5
    output logic      [3:0]         compare_pin,
    output logic      [3:0]         compare_pin_oe,
    // Counter, third timer prescale and interrupt requests
    output logic      [15:0]        free_running_counter,
    output logic      [1:0]         third_timer_prescale,
    output logic      [7:0]         irq_request1,
    output logic      [3:0]         irq_request2
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  pin_action;      // compare_pin_action_control
        logic [7:0]  irq_enable1;     // capture_compare_irq_enable
        logic [7:0]  flags1;          // capture_compare_event_flags
        logic [3:0]  irq_enable2;     // Upper nibble of the second enable
        logic [1:0]  prescale;        // counter_prescale_select
        logic        prescale_locked;
        logic [3:0]  flags2;          // Upper nibble of the second flags
        logic [4:0]  aux;             // Select, special mode, third override
        logic [6:0]  boot_count;
        logic [3:0]  div_count;
        logic [15:0] counter;
        logic        tick;            // Counter took a new value
        logic [3:0]  cap_meta;
        logic [3:0]  cap_sync;
        logic [3:0]  cap_prev;
        logic [3:0]  pins;
        logic        ack;
        logic [31:0] rdata;
    } tcic_state_type;

    tcic_state_type state;
    tcic_state_type next_state;

    // ----------------------------------------------------------------
    // Decode and helpers
    // ----------------------------------------------------------------
    logic        access;
    logic        bus_write;
    logic        mapped;
    logic        ch45_sel;
    logic        special;
    logic        div_done;
    logic [3:0]  div_limit;
    logic [4:0]  match;
    logic [3:0]  cap_edge;
    logic [7:0]  set1;
    logic [3:0]  set2;
    logic [7:0]  read_byte;
    logic        prescale_ok;

    // Bus phase decode; writes land at the pready edge
    assign access    = psel & penable;
    assign bus_write = access & state.ack & pwrite;
    assign mapped    = (paddr == ADDR_PIN_ACTION) || (paddr == ADDR_IRQ_ENABLE1)
                    || (paddr == ADDR_FLAGS1) || (paddr == ADDR_IRQ_ENABLE2)
                    || (paddr == ADDR_FLAGS2) || (paddr == ADDR_AUX_CONTROL);
    assign ch45_sel  = state.aux[AUX_CH45_SEL];
    assign special   = state.aux[AUX_SPECIAL];

    // Prescaler terminal count
    always_comb begin
        unique case (state.prescale)                                 // RULE12
            2'b00: div_limit = DIV_LIMIT_1;
            2'b01: div_limit = DIV_LIMIT_4;
            2'b10: div_limit = DIV_LIMIT_8;
            2'b11: div_limit = DIV_LIMIT_16;
        endcase
    end
    assign div_done = (state.div_count == div_limit);

    // Compare once per new counter value, checked only in the tick cycle
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            match[i] = state.tick && (state.counter == compare_value[i]); // RULE20
        end
    end

    // Edge detection on synchronised capture pins
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            unique case (capture_edge_select[2*i +: 2])
                EDGE_RISE: cap_edge[i] = state.cap_sync[i] & ~state.cap_prev[i];
                EDGE_FALL: cap_edge[i] = ~state.cap_sync[i] & state.cap_prev[i];
                EDGE_ANY:  cap_edge[i] = state.cap_sync[i] ^ state.cap_prev[i];
                default:   cap_edge[i] = 1'b0;
            endcase
        end
    end

    // Flag set events, independent of the enables
    always_comb begin
        set1 = RST_BYTE;
        for (int i = 0; i < 4; i++) begin
            set1[FLG1_CMP1 - i] = match[i];                           // RULE7 RULE17
        end
        for (int i = 0; i < 3; i++) begin
            set1[FLG1_CAP1 - i] = cap_edge[i];                        // RULE9
        end
        set1[FLG1_CH45] = ch45_sel ? cap_edge[3] : match[4];          // RULE8 RULE2
        set2 = RST_NIBBLE;
        set2[FLG2_OVERFLOW] = div_done && (state.counter == COUNTER_MAX); // RULE15
        set2[FLG2_PERIODIC] = periodic_event;
        set2[FLG2_ACC_OVF]  = accumulator_overflow_event;
        set2[FLG2_ACC_EDGE] = accumulator_edge_event;
    end

    // Read multiplexer; unused bits read zero
    always_comb begin
        unique case (paddr)
            ADDR_PIN_ACTION:  read_byte = state.pin_action;
            ADDR_IRQ_ENABLE1: read_byte = state.irq_enable1;
            ADDR_FLAGS1:      read_byte = state.flags1;
            ADDR_IRQ_ENABLE2: read_byte = {state.irq_enable2, 2'b00, state.prescale};
            ADDR_FLAGS2:      read_byte = {state.flags2, RST_NIBBLE};     // RULE16
            ADDR_AUX_CONTROL: read_byte = {3'b000, state.aux};
            default:          read_byte = RST_BYTE;
        endcase
    end

    // One write, inside the window after reset, unless in special mode
    assign prescale_ok = special
                      || (!state.prescale_locked && state.boot_count < PRESCALE_WINDOW); // RULE13

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        // Bus handshake: one wait cycle, read data captured in it
        next_state.ack = access & ~state.ack;
        if (access && !state.ack) begin
            next_state.rdata = {24'h00_0000, read_byte};
        end
        // Cycle count since reset, saturating
        if (state.boot_count < PRESCALE_WINDOW) begin
            next_state.boot_count = 7'(state.boot_count + 7'd1);
        end
        // Prescaler and free-running counter
        next_state.tick = div_done;
        if (div_done) begin
            next_state.div_count = RST_NIBBLE;
            next_state.counter   = 16'(state.counter + 16'd1);
        end else begin
            next_state.div_count = 4'(state.div_count + 4'd1);
        end
        // Capture pin synchronisers
        next_state.cap_meta = capture_pin;
        next_state.cap_sync = state.cap_meta;
        next_state.cap_prev = state.cap_sync;
        // Pin actions on every match, flag state ignored
        for (int i = 0; i < 4; i++) begin
            if (match[i + 1] && !(i == 3 && ch45_sel)) begin          // RULE2 RULE19
                unique case (state.pin_action[7 - 2*i -: 2])         // RULE1
                    ACT_DETACH: next_state.pins[i] = state.pins[i];
                    ACT_TOGGLE: next_state.pins[i] = ~state.pins[i];
                    ACT_LOW:    next_state.pins[i] = 1'b0;
                    ACT_HIGH:   next_state.pins[i] = 1'b1;
                endcase
            end
        end
        // Flags: clear where a one is written, set wins
        next_state.flags1 = state.flags1 | set1;                      // RULE21
        next_state.flags2 = state.flags2 | set2;
        if (bus_write && paddr == ADDR_FLAGS1) begin
            next_state.flags1 = (state.flags1 & ~pwdata[7:0]) | set1; // RULE6 RULE21
        end
        if (bus_write && paddr == ADDR_FLAGS2) begin
            next_state.flags2 = (state.flags2 & ~pwdata[7:4]) | set2; // RULE6 RULE21
        end
        // Plain register writes
        if (bus_write && paddr == ADDR_PIN_ACTION) begin
            next_state.pin_action = pwdata[7:0];
        end
        if (bus_write && paddr == ADDR_IRQ_ENABLE1) begin
            next_state.irq_enable1 = pwdata[7:0];                     // RULE3 RULE5
        end
        if (bus_write && paddr == ADDR_IRQ_ENABLE2) begin
            next_state.irq_enable2 = pwdata[7:4];                     // RULE10 RULE11
            if (prescale_ok) begin
                next_state.prescale = pwdata[1:0];                    // RULE13
            end
            if (!special) begin
                next_state.prescale_locked = 1'b1;
            end
        end
        if (bus_write && paddr == ADDR_AUX_CONTROL) begin
            next_state.aux = pwdata[4:0];
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Bus answer
    assign pready  = access & state.ack;
    assign pslverr = access & state.ack & ~mapped;
    assign prdata  = state.rdata;

    // Compare pins driven while their pair is not detached; channel 5 also needs the select clear
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            compare_pin_oe[i] = (state.pin_action[7 - 2*i -: 2] != ACT_DETACH)
                             && !(i == 3 && ch45_sel);                // RULE1 RULE2
        end
    end
    assign compare_pin = state.pins;

    // Separate request per source
    assign irq_request1 = state.flags1 & state.irq_enable1;           // RULE3 RULE4 RULE18
    assign irq_request2 = state.flags2 & state.irq_enable2;           // RULE10 RULE18

    // Counter and third timer prescale
    assign free_running_counter = state.counter;
    assign third_timer_prescale = state.aux[AUX_T3_OVR]
                               ? state.aux[AUX_T3_PR_LO +: 2] : state.prescale; // RULE14

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_drive_high;
        match[1] && state.pin_action[7:6] == ACT_HIGH |=> compare_pin[0];
    endproperty
    a_drive_high: assert property (p_drive_high) else $error("pin not driven high"); // RULE1

    property p_toggle_each;
        match[2] && state.pin_action[5:4] == ACT_TOGGLE
            |=> compare_pin[1] != $past(compare_pin[1]);
    endproperty
    a_toggle_each: assert property (p_toggle_each) else $error("toggle missed"); // RULE19

    property p_ch5_gated;
        ch45_sel |=> $stable(compare_pin[3]);
    endproperty
    a_ch5_gated: assert property (p_ch5_gated) else $error("channel 5 moved"); // RULE2

    property p_irq_follows;
        match[0] && state.irq_enable1[FLG1_CMP1] && !bus_write |=> irq_request1[FLG1_CMP1];
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("no irq on match"); // RULE4

    property p_flag_on_match;
        match[1] |=> state.flags1[FLG1_CMP1 - 1];
    endproperty
    a_flag_on_match: assert property (p_flag_on_match) else $error("flag not set"); // RULE7

    property p_overflow;
        div_done && state.counter == COUNTER_MAX
            |=> state.counter == RST_COUNTER && state.flags2[FLG2_OVERFLOW];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag missing"); // RULE15

    property p_lock;
        state.prescale_locked && !special |=> $stable(state.prescale);
    endproperty
    a_lock: assert property (p_lock) else $error("prescale changed after lock"); // RULE13

    property p_zero_keeps;
        bus_write && paddr == ADDR_FLAGS1 && !pwdata[FLG1_CMP1] && state.flags1[FLG1_CMP1]
            |=> state.flags1[FLG1_CMP1];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost on zero"); // RULE21

    property p_one_clears;
        bus_write && paddr == ADDR_FLAGS1 && pwdata[FLG1_CAP1] && !cap_edge[0]
            |=> !state.flags1[FLG1_CAP1];
    endproperty
    a_one_clears: assert property (p_one_clears) else $error("flag not cleared"); // RULE6

    property p_low_nibble;
        pready && !pwrite && paddr == ADDR_FLAGS2 |-> prdata[3:0] == RST_NIBBLE;
    endproperty
    a_low_nibble: assert property (p_low_nibble) else $error("reserved bits set"); // RULE16

    property p_div16;
        div_done && state.prescale == 2'b11 && !bus_write |=> !div_done [*8];
    endproperty
    a_div16: assert property (p_div16) else $error("divide by 16 too fast"); // RULE12

    property p_window_shut;
        !special && state.boot_count == PRESCALE_WINDOW |=> $stable(state.prescale);
    endproperty
    a_window_shut: assert property (p_window_shut) else $error("late prescale write"); // RULE13

    property p_cap4_flag;
        ch45_sel && cap_edge[3] |=> state.flags1[FLG1_CH45];
    endproperty
    a_cap4_flag: assert property (p_cap4_flag) else $error("no capture 4 flag"); // RULE8

    property p_cmp5_flag;
        !ch45_sel && match[4] |=> state.flags1[FLG1_CH45];
    endproperty
    a_cmp5_flag: assert property (p_cmp5_flag) else $error("no compare 5 flag"); // RULE8

    property p_periodic_set;
        periodic_event |=> state.flags2[FLG2_PERIODIC];
    endproperty
    a_periodic_set: assert property (p_periodic_set) else $error("no periodic flag"); // RULE17

    c_toggle:   cover property (match[2] && state.pin_action[5:4] == ACT_TOGGLE);
    c_overflow: cover property (set2[FLG2_OVERFLOW]);
    c_capture4: cover property (ch45_sel && cap_edge[3]);
    c_prescale: cover property (bus_write && paddr == ADDR_IRQ_ENABLE2 && prescale_ok);

endmodule : tcic_timer1_ctrl
`default_nettype wire

// [tcic_pin_model.sv]
// Pin-side model: drives the capture inputs and watches the compare pins
`timescale 1ns/1ps
`default_nettype none
module tcic_pin_model (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       level,
    input  wire logic [3:0] compare_pin,
    input  wire logic [3:0] compare_pin_oe,
    output logic      [3:0] capture_pin,
    output logic      [3:0] pin_seen
);
    // Capture lines follow the requested level one clock later
    always_ff @(posedge clk) begin
        if (srst) begin
            capture_pin <= 4'h0;
        end else begin
            capture_pin <= {4{level}};
        end
    end

    // A released compare pin shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_seen[i] = compare_pin_oe[i] ? compare_pin[i] : ~compare_pin[i];
        end
    end
endmodule : tcic_pin_model
`default_nettype wire

// [tb_timer1_compare_irq_control.sv]
// Self-checking bench for the first timer compare and interrupt control
`timescale 1ns/1ps
`default_nettype none
module tb_timer1_compare_irq_control
    import tcic_pkg::*;
;
    logic             clk = 1'b0;
    logic             srst = 1'b1;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rslv;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0000_0000, prdata, rdata;
    logic             pready, pslverr, level = 1'b0;
    logic             pe = 1'b0, aoe = 1'b0, aee = 1'b0;
    logic [4:0][15:0] cv = {5{16'hffff}};
    logic [7:0]       edge_sel = 8'h00, irq1;
    logic [3:0]       capture_pin, compare_pin, compare_pin_oe, pin_seen, irq2;
    logic [15:0]      frc, c0;
    logic [1:0]       ttp;
    int               errors = 0, n_tests = 0, cyc = 0;

    tcic_timer1_ctrl tcic_timer1_ctrl_i (.clk(clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .compare_value(cv),
        .capture_pin(capture_pin), .capture_edge_select(edge_sel),
        .periodic_event(pe), .accumulator_overflow_event(aoe),
        .accumulator_edge_event(aee), .compare_pin(compare_pin),
        .compare_pin_oe(compare_pin_oe), .free_running_counter(frc),
        .third_timer_prescale(ttp), .irq_request1(irq1), .irq_request2(irq2));
    tcic_pin_model tcic_pin_model_i (.clk(clk), .srst(srst), .level(level),
        .compare_pin(compare_pin), .compare_pin_oe(compare_pin_oe),
        .capture_pin(capture_pin), .pin_seen(pin_seen));

    // Clock and hang guard
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rslv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rdata, exp);
    endtask : rchk
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_prescale;
        apb(1'b1, ADDR_IRQ_ENABLE2, 8'hf0);
        rchk(ADDR_IRQ_ENABLE2, 32'h0000_00f0);
        apb(1'b1, ADDR_IRQ_ENABLE2, 8'hf3);
        rchk(ADDR_IRQ_ENABLE2, 32'h0000_00f0);
        @(posedge clk);
        c0 = frc;
        @(posedge clk);
        chk(frc, c0 + 16'h0001);
        chk(ttp, 2'b00);
        apb(1'b1, ADDR_AUX_CONTROL, 8'h14);
        rchk(ADDR_PIN_ACTION, 32'h0000_0000);
        chk(ttp, 2'b10);
        rchk(ADDR_IRQ_ENABLE1, 32'h0000_0000);
        rchk(ADDR_FLAGS1, 32'h0000_0000);
        rchk(ADDR_FLAGS2, 32'h0000_0000);
        rchk(12'h0fc, 32'h0000_0000);
        chk(rslv, 1'b1);
        // Special mode reopens the select: divide by 16, then back to 1
        apb(1'b1, ADDR_AUX_CONTROL, 8'h02);
        apb(1'b1, ADDR_IRQ_ENABLE2, 8'hf3);
        c0 = frc;
        repeat (32) @(posedge clk);
        chk(frc - c0, 16'h0002);
        chk(ttp, 2'b11);
        apb(1'b1, ADDR_IRQ_ENABLE2, 8'hf0);
        $display("test prescale_reset done");
    endtask : t_prescale
    task automatic t_compare;
        apb(1'b1, ADDR_AUX_CONTROL, 8'h00);
        apb(1'b1, ADDR_IRQ_ENABLE1, 8'h80);
        apb(1'b1, ADDR_PIN_ACTION, 8'he4);
        cv <= {5{frc + 16'h0014}};
        repeat (30) @(posedge clk);
        rchk(ADDR_FLAGS1, 32'h0000_00f8);
        chk(compare_pin_oe, 4'b0111);
        chk(pin_seen[2:0], 3'b101);
        chk(irq1, 8'h80);
        apb(1'b1, ADDR_PIN_ACTION, 8'h1b);
        cv <= {5{frc + 16'h0014}};
        repeat (30) @(posedge clk);
        chk(compare_pin_oe, 4'b1110);
        chk(pin_seen[3:1], 3'b101);
        apb(1'b1, ADDR_FLAGS1, 8'h0f);
        rchk(ADDR_FLAGS1, 32'h0000_00f0);
        apb(1'b1, ADDR_FLAGS1, 8'hff);
        rchk(ADDR_FLAGS1, 32'h0000_0000);
        chk(irq1, 8'h00);
        $display("test compare done");
    endtask : t_compare
    task automatic t_capture;
        apb(1'b1, ADDR_AUX_CONTROL, 8'h01);
        apb(1'b1, ADDR_IRQ_ENABLE1, 8'h08);
        chk(compare_pin_oe[3], 1'b0);
        edge_sel <= 8'h79;
        level <= 1'b1;
        repeat (10) @(posedge clk);
        rchk(ADDR_FLAGS1, 32'h0000_000d);
        chk(irq1, 8'h08);
        apb(1'b1, ADDR_FLAGS1, 8'h0d);
        level <= 1'b0;
        repeat (10) @(posedge clk);
        rchk(ADDR_FLAGS1, 32'h0000_0003);
        $display("test capture done");
    endtask : t_capture
    task automatic t_events;
        pe <= 1'b1;
        aoe <= 1'b1;
        aee <= 1'b1;
        @(posedge clk);
        pe <= 1'b0;
        aoe <= 1'b0;
        aee <= 1'b0;
        rchk(ADDR_FLAGS2, 32'h0000_0070);
        chk(irq2, 4'b0111);
        apb(1'b1, ADDR_FLAGS2, 8'h2f);
        rchk(ADDR_FLAGS2, 32'h0000_0050);
        while (frc !== 16'hffff) @(posedge clk);
        repeat (3) @(posedge clk);
        rchk(ADDR_FLAGS2, 32'h0000_00d0);
        chk(irq2, 4'b1101);
        $display("test events done");
    endtask : t_events

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_prescale();
        t_compare();
        t_capture();
        t_events();
        results();
    end
endmodule : tb_timer1_compare_irq_control
`default_nettype wire
